// ===== sim/pin_world.sv
`timescale 1ns/10ps
module pin_world (
  // pins from the port block
  input  wire logic [8:0]  disc_out,
  input  wire logic [8:0]  disc_oe,
  input  wire logic [23:0] nib_out,
  input  wire logic [23:0] nib_oe,
  // outside levels
  input  wire logic [8:0]  disc_ext,
  input  wire logic [23:0] nib_ext,
  input  wire logic        single_ext,
  input  wire logic        alarm_ext,
  // resolved levels back into the block
  output logic      [8:0]  disc_in,
  output logic      [23:0] nib_in,
  output logic             single_in,
  output logic             alarm_in
);
  // released pins show the outside drive, never the last driven level
  assign disc_in   = (disc_oe & disc_out) | (~disc_oe & disc_ext);
  assign nib_in    = (nib_oe & nib_out) | (~nib_oe & nib_ext);
  assign single_in = single_ext;
  assign alarm_in  = alarm_ext;
endmodule

// ===== sim/test_discrete_and_nibble_port_io.sv
`timescale 1ns/10ps
module test_discrete_and_nibble_port_io;
  typedef struct packed {logic [2:0] port; logic [3:0] wdata; logic [3:0] rexp;} row_t;
  logic        ref_clk, arst_n, stop_mode, set_discrete_bit, clear_discrete_bit;
  logic        nibble_write, nibble_read, reg_write, nibble_rvalid, single_input_bit;
  logic        alarm_output, stop_clear_input_n, timer_event_input;
  logic        external_irq_zero_n, external_irq_one_n, single_ext, alarm_ext;
  logic [3:0]  discrete_index, nibble_wdata, nibble_rdata, reg_wdata;
  logic [3:0]  port_mode_a, serial_mode, converter_mode_one, converter_mode_two;
  logic [2:0]  nibble_port;
  logic [6:0]  reg_addr;
  logic [8:0]  discrete_pin_in, discrete_pin_out, discrete_pin_oe, disc_ext;
  logic [23:0] nibble_pin_in, nibble_pin_out, nibble_pin_oe, nib_ext;
  int          mismatches, samples_checked, n;
  row_t        rows[8];

  discrete_and_nibble_port_io #(.DISC_PINS(9)) discrete_and_nibble_port_io_i (
    .ref_clk, .arst_n, .stop_mode, .set_discrete_bit, .clear_discrete_bit, .discrete_index,
    .nibble_write, .nibble_read, .nibble_port, .nibble_wdata, .nibble_rdata, .nibble_rvalid,
    .reg_write, .reg_addr, .reg_wdata, .discrete_pin_in, .discrete_pin_out, .discrete_pin_oe,
    .nibble_pin_in, .nibble_pin_out, .nibble_pin_oe, .single_input_bit, .alarm_output,
    .stop_clear_input_n, .timer_event_input, .external_irq_zero_n, .external_irq_one_n,
    .port_mode_a, .serial_mode, .converter_mode_one, .converter_mode_two);

  pin_world pin_world_i (
    .disc_out(discrete_pin_out), .disc_oe(discrete_pin_oe), .nib_out(nibble_pin_out),
    .nib_oe(nibble_pin_oe), .disc_ext, .nib_ext, .single_ext, .alarm_ext,
    .disc_in(discrete_pin_in), .nib_in(nibble_pin_in), .single_in(single_input_bit),
    .alarm_in(alarm_output));

  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic close_out();
    if (mismatches == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input logic [23:0] seen, input logic [23:0] want);
    samples_checked++;
    if (seen !== want)
    begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, want);
    end
  endtask

  // every strobe is one cycle wide, followed by an idle cycle
  task automatic wreg(input logic [6:0] a, input logic [3:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(negedge ref_clk);
    reg_write = 1'b0;
    @(negedge ref_clk);
  endtask

  task automatic disc(input logic s, input logic c, input logic [3:0] i);
    discrete_index = i;
    set_discrete_bit = s;
    clear_discrete_bit = c;
    @(negedge ref_clk);
    set_discrete_bit = 1'b0;
    clear_discrete_bit = 1'b0;
    @(negedge ref_clk);
  endtask

  task automatic nread(input logic [2:0] p, input logic [3:0] want);
    nibble_port = p;
    nibble_read = 1'b1;
    @(negedge ref_clk);
    nibble_read = 1'b0;
    for (n = 0; n < 4 && nibble_rvalid !== 1'b1; n++) @(negedge ref_clk);
    if (n == 4)
    begin
      mismatches++;
      close_out();
    end
    else
    begin
      check(24'(nibble_rdata), 24'(want));
      @(negedge ref_clk);
      check(24'(nibble_rvalid), 24'h000000);
    end
  endtask

  initial
  begin
    {stop_mode, set_discrete_bit, clear_discrete_bit, nibble_write, nibble_read} = 5'h00;
    {reg_write, alarm_ext, arst_n} = 3'h0;
    {discrete_index, nibble_wdata, reg_wdata, nibble_port, reg_addr} = 22'h000000;
    disc_ext = 9'h000;
    nib_ext = 24'h000000;
    single_ext = 1'b1;
    rows = '{'{3'h0, 4'hA, 4'hA}, '{3'h1, 4'h5, 4'h5}, '{3'h2, 4'hC, 4'hC},
             '{3'h3, 4'h3, 4'h3}, '{3'h4, 4'h9, 4'h9}, '{3'h5, 4'h6, 4'h6},
             '{3'h6, 4'h0, 4'h2}, '{3'h7, 4'h0, 4'h0}};
    repeat (4) @(negedge ref_clk);
    check(nibble_pin_out, 24'h0FF00F);
    check(nibble_pin_oe, 24'h000000);
    check(24'(discrete_pin_oe), 24'h000000);
    check(24'({external_irq_zero_n, external_irq_one_n}), 24'h000003);
    check(24'({stop_clear_input_n, timer_event_input}), 24'h000002);
    arst_n = 1'b1;
    @(negedge ref_clk);
    wreg(7'h30, 4'hF);
    wreg(7'h33, 4'hF);
    wreg(7'h34, 4'hF);
    check(nibble_pin_oe, 24'h0FF00F);
    // ports without a latch are only read
    foreach (rows[r])
    begin
      if (rows[r].port < 3'h6)
      begin
        nibble_port = rows[r].port;
        nibble_wdata = rows[r].wdata;
        nibble_write = 1'b1;
        @(negedge ref_clk);
        nibble_write = 1'b0;
        @(negedge ref_clk);
      end
      nread(rows[r].port, rows[r].rexp);
    end
    // released pins show the outside level, driven ones their latch
    single_ext = 1'b0;
    nread(3'h6, 4'h0);
    nib_ext = 24'hFFFFFF;
    nread(3'h1, 4'hF);
    nread(3'h0, 4'hA);
    nib_ext = 24'h000000;
    for (int i = 0; i < 9; i++)
    begin
      disc(1'b1, 1'b0, 4'(i));
      check(24'({discrete_pin_out[i], discrete_pin_oe[i]}), 24'h000003);
      disc(1'b0, 1'b1, 4'(i));
      check(24'({discrete_pin_out[i], discrete_pin_oe[i]}), 24'h000000);
    end
    // set and clear in one cycle: set wins
    disc(1'b1, 1'b1, 4'h6);
    check(24'(discrete_pin_out[6]), 24'h000001);
    disc(1'b0, 1'b1, 4'h6);
    disc(1'b1, 1'b0, 4'h9);
    check(24'(discrete_pin_oe), 24'h000000);
    wreg(7'h30, 4'h0);
    check(24'(nibble_pin_oe[3:0]), 24'h000000);
    wreg(7'h7F, 4'hF);
    check(24'({port_mode_a, nibble_pin_oe[3:0]}), 24'h000000);
    wreg(7'h05, 4'h9);
    wreg(7'h19, 4'h6);
    wreg(7'h1A, 4'hC);
    check(24'({serial_mode, converter_mode_one, converter_mode_two}), 24'h00096C);
    disc(1'b1, 1'b0, 4'h0);
    disc(1'b1, 1'b0, 4'h1);
    disc(1'b1, 1'b0, 4'h2);
    disc(1'b1, 1'b0, 4'h4);
    wreg(7'h24, 4'hF);
    wreg(7'h04, 4'h8);
    alarm_ext = 1'b1;
    repeat (2) @(negedge ref_clk);
    check(24'(discrete_pin_oe[4:0]), 24'h000008);
    check(24'({port_mode_a, discrete_pin_out[3]}), 24'h000011);
    check(24'({external_irq_zero_n, external_irq_one_n}), 24'h000000);
    check(24'(stop_clear_input_n), 24'h000000);
    disc_ext = 9'h005;
    alarm_ext = 1'b0;
    repeat (2) @(negedge ref_clk);
    check(24'({timer_event_input, external_irq_zero_n}), 24'h000003);
    check(24'(discrete_pin_oe[3]), 24'h000000);
    discrete_index = 4'h8;
    set_discrete_bit = 1'b1;
    @(negedge ref_clk);
    set_discrete_bit = 1'b0;
    stop_mode = 1'b1;
    repeat (2) @(negedge ref_clk);
    // writes are refused while stopped
    wreg(7'h04, 4'h8);
    check(24'(discrete_pin_out), 24'h000000);
    check(nibble_pin_out, 24'h0FF00F);
    check(24'({port_mode_a, stop_clear_input_n}), 24'h000001);
    stop_mode = 1'b0;
    disc(1'b1, 1'b0, 4'h5);
    check(24'(discrete_pin_oe[5]), 24'h000001);
    // reset in mid-run with a latch set
    arst_n = 1'b0;
    @(negedge ref_clk);
    check(24'(discrete_pin_oe), 24'h000000);
    check(nibble_pin_out, 24'h0FF00F);
    arst_n = 1'b1;
    @(negedge ref_clk);
    disc(1'b1, 1'b0, 4'h5);
    check(24'({discrete_pin_out[5], discrete_pin_oe[5]}), 24'h000003);
    close_out();
  end
endmodule

// ===== verilog/discrete_and_nibble_port_io.sv
`timescale 1ns/10ps
// Contract
// RULE1: nine discrete latches, set and clear instructions
// RULE2: discrete latches zero on reset and stop
// RULE3: port_mode_b four bit write-only, resets zero
// RULE4: port_mode_a bit3 selects alarm on pin3
// RULE5: port_mode_b bit3 selects stop clear on pin4
// RULE6: port_mode_b bit2 selects timer event pin2
// RULE7: port_mode_b bit1 routes pin1 to irq1
// RULE8: port_mode_b bit0 routes pin0 to irq0
// RULE9: six nibble ports plus single-bit input
// RULE10: nibble write stores latch, read returns pins
// RULE11: single-bit port carries level in bit1
// RULE12: direction bit one enables standard pin driver
// RULE13: direction registers write-only at 030,033,034
// RULE14: standard latches reset one, high-voltage zero
// RULE15: direction zero is high impedance, resets zero
// RULE16: high-voltage latch one drives high, zero open
// RULE17: peripheral pins bypass latch, inputs see pin
// RULE18: write-only registers kept internally for pins
module discrete_and_nibble_port_io #(
  parameter int DISC_PINS = 9
) (
  // clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 arst_n,
  input  wire logic                 stop_mode,
  // discrete bit instructions
  input  wire logic                 set_discrete_bit,
  input  wire logic                 clear_discrete_bit,
  input  wire logic [3:0]           discrete_index,
  // nibble instructions
  input  wire logic                 nibble_write,
  input  wire logic                 nibble_read,
  input  wire logic [2:0]           nibble_port,
  input  wire logic [3:0]           nibble_wdata,
  output logic      [3:0]           nibble_rdata,
  output logic                      nibble_rvalid,
  // memory-mapped register writes
  input  wire logic                 reg_write,
  input  wire logic [6:0]           reg_addr,
  input  wire logic [3:0]           reg_wdata,
  // discrete pins
  input  wire logic [DISC_PINS-1:0] discrete_pin_in,
  output logic      [DISC_PINS-1:0] discrete_pin_out,
  output logic      [DISC_PINS-1:0] discrete_pin_oe,
  // nibble pins, ports 0,1,2,3,4,8 packed low to high
  input  wire logic [23:0]          nibble_pin_in,
  output logic      [23:0]          nibble_pin_out,
  output logic      [23:0]          nibble_pin_oe,
  input  wire logic                 single_input_bit,
  // peripheral connections
  input  wire logic                 alarm_output,
  output logic                      stop_clear_input_n,
  output logic                      timer_event_input,
  output logic                      external_irq_zero_n,
  output logic                      external_irq_one_n,
  // mode copies for other peripherals
  output logic      [3:0]           port_mode_a,
  output logic      [3:0]           serial_mode,
  output logic      [3:0]           converter_mode_one,
  output logic      [3:0]           converter_mode_two
);

  typedef struct packed {
    logic [DISC_PINS-1:0] disc_lat;
    logic [3:0]           mode_a;
    logic [3:0]           mode_b;
    logic [3:0]           ser_mode;
    logic [3:0]           conv_one;
    logic [3:0]           conv_two;
    logic [3:0]           dir0;
    logic [3:0]           dir3;
    logic [3:0]           dir4;
    logic [23:0]          nib_lat;
    logic [3:0]           rdata;
    logic                 rvalid;
    logic [DISC_PINS-1:0] d_out;
    logic [DISC_PINS-1:0] d_oe;
    logic [23:0]          n_out;
    logic [23:0]          n_oe;
    logic                 wake_n;
    logic                 evt;
    logic                 irq0_n;
    logic                 irq1_n;
  } state_t;

  // standard pins are ports 0,3,4: nibbles 0,3,4 of the packed vector
  localparam logic [23:0] STD_MASK = 24'h0FF00F;
  localparam logic [23:0] NIB_LAT_RESET =
    (STD_MASK & {6{port_io_pkg::STD_LAT_RESET}}) |
    (~STD_MASK & {6{port_io_pkg::HV_LAT_RESET}});

  state_t st;
  state_t next_st;
  logic [23:0] dir_all;
  logic [3:0]  pin_nib;

  always_comb
  begin
    next_st = st;
    next_st.rvalid = 1'b0;
    dir_all = '0;
    pin_nib = 4'h0;
    if (stop_mode)
    begin
      // stop clears every latch, mode and direction register to its reset state
      next_st.disc_lat = port_io_pkg::DISC_LAT_RESET; // RULE2
      next_st.nib_lat  = NIB_LAT_RESET; // RULE14
      next_st.mode_a   = port_io_pkg::MODE_RESET;
      next_st.mode_b   = port_io_pkg::MODE_RESET; // RULE3
      next_st.ser_mode = port_io_pkg::MODE_RESET;
      next_st.conv_one = port_io_pkg::MODE_RESET;
      next_st.conv_two = port_io_pkg::MODE_RESET;
      next_st.dir0     = port_io_pkg::DIR_RESET; // RULE15
      next_st.dir3     = port_io_pkg::DIR_RESET;
      next_st.dir4     = port_io_pkg::DIR_RESET;
    end
    else
    begin
      if (int'(discrete_index) < DISC_PINS)
      begin
        // set wins when both arrive together
        if (clear_discrete_bit)
          next_st.disc_lat[discrete_index] = 1'b0; // RULE1
        if (set_discrete_bit)
          next_st.disc_lat[discrete_index] = 1'b1; // RULE1
      end
      if (nibble_write)
      begin
        case (nibble_port) // RULE9
          port_io_pkg::NPORT_ZERO:  next_st.nib_lat[3:0]   = nibble_wdata; // RULE10
          port_io_pkg::NPORT_ONE:   next_st.nib_lat[7:4]   = nibble_wdata;
          port_io_pkg::NPORT_TWO:   next_st.nib_lat[11:8]  = nibble_wdata;
          port_io_pkg::NPORT_THREE: next_st.nib_lat[15:12] = nibble_wdata;
          port_io_pkg::NPORT_FOUR:  next_st.nib_lat[19:16] = nibble_wdata;
          port_io_pkg::NPORT_EIGHT: next_st.nib_lat[23:20] = nibble_wdata;
          default: ;
        endcase
      end
      if (reg_write)
      begin
        // write-only: no read path, internal copies drive the pins
        case (reg_addr) // RULE18
          port_io_pkg::OFS_PORT_MODE_A:    next_st.mode_a   = reg_wdata;
          port_io_pkg::OFS_SERIAL_MODE:    next_st.ser_mode = reg_wdata;
          port_io_pkg::OFS_CONV_MODE_ONE:  next_st.conv_one = reg_wdata;
          port_io_pkg::OFS_CONV_MODE_TWO:  next_st.conv_two = reg_wdata;
          port_io_pkg::OFS_PORT_MODE_B:    next_st.mode_b   = reg_wdata; // RULE3
          port_io_pkg::OFS_DIR_PORT_ZERO:  next_st.dir0     = reg_wdata; // RULE13
          port_io_pkg::OFS_DIR_PORT_THREE: next_st.dir3     = reg_wdata; // RULE13
          port_io_pkg::OFS_DIR_PORT_FOUR:  next_st.dir4     = reg_wdata; // RULE13
          default: ;
        endcase
      end
    end
    if (nibble_read)
    begin
      case (nibble_port)
        port_io_pkg::NPORT_ZERO:   pin_nib = nibble_pin_in[3:0]; // RULE10
        port_io_pkg::NPORT_ONE:    pin_nib = nibble_pin_in[7:4];
        port_io_pkg::NPORT_TWO:    pin_nib = nibble_pin_in[11:8];
        port_io_pkg::NPORT_THREE:  pin_nib = nibble_pin_in[15:12];
        port_io_pkg::NPORT_FOUR:   pin_nib = nibble_pin_in[19:16];
        port_io_pkg::NPORT_EIGHT:  pin_nib = nibble_pin_in[23:20];
        // undefined bits read as zero
        port_io_pkg::NPORT_SINGLE:
          pin_nib[port_io_pkg::SINGLE_INPUT_BIT] = single_input_bit; // RULE11
        default: pin_nib = 4'h0;
      endcase
      next_st.rdata  = pin_nib;
      next_st.rvalid = 1'b1;
    end
    // pin drive from the next state so outputs follow with no extra lag
    next_st.d_out = next_st.disc_lat; // RULE16
    next_st.d_oe  = next_st.disc_lat; // RULE16
    // alarm replaces latch on pin3; latch stays off the pin
    if (next_st.mode_a[port_io_pkg::ALARM_SEL_BIT])
    begin
      next_st.d_out[port_io_pkg::PIN_ALARM] = alarm_output; // RULE4 RULE17
      next_st.d_oe[port_io_pkg::PIN_ALARM]  = alarm_output; // RULE4
    end
    // peripheral inputs release the latch driver
    if (next_st.mode_b[port_io_pkg::STOP_CLEAR_SEL_BIT])
    begin
      next_st.d_out[port_io_pkg::PIN_WAKE] = 1'b0; // RULE5 RULE17
      next_st.d_oe[port_io_pkg::PIN_WAKE]  = 1'b0;
    end
    if (next_st.mode_b[port_io_pkg::EVENT_SEL_BIT])
    begin
      next_st.d_out[port_io_pkg::PIN_EVENT] = 1'b0; // RULE6 RULE17
      next_st.d_oe[port_io_pkg::PIN_EVENT]  = 1'b0;
    end
    if (next_st.mode_b[port_io_pkg::IRQ1_SEL_BIT])
    begin
      next_st.d_out[port_io_pkg::PIN_IRQ1] = 1'b0; // RULE7 RULE17
      next_st.d_oe[port_io_pkg::PIN_IRQ1]  = 1'b0;
    end
    if (next_st.mode_b[port_io_pkg::IRQ0_SEL_BIT])
    begin
      next_st.d_out[port_io_pkg::PIN_IRQ0] = 1'b0; // RULE8 RULE17
      next_st.d_oe[port_io_pkg::PIN_IRQ0]  = 1'b0;
    end
    // unselected peripheral inputs idle inactive
    next_st.wake_n  = next_st.mode_b[port_io_pkg::STOP_CLEAR_SEL_BIT] ?
                      discrete_pin_in[port_io_pkg::PIN_WAKE] : 1'b1; // RULE5
    next_st.evt     = next_st.mode_b[port_io_pkg::EVENT_SEL_BIT] ?
                      discrete_pin_in[port_io_pkg::PIN_EVENT] : 1'b0; // RULE6
    next_st.irq1_n  = next_st.mode_b[port_io_pkg::IRQ1_SEL_BIT] ?
                      discrete_pin_in[port_io_pkg::PIN_IRQ1] : 1'b1; // RULE7
    next_st.irq0_n  = next_st.mode_b[port_io_pkg::IRQ0_SEL_BIT] ?
                      discrete_pin_in[port_io_pkg::PIN_IRQ0] : 1'b1; // RULE8
    // standard pins: direction enables; high-voltage: latch one drives high
    dir_all = {4'h0, next_st.dir4, next_st.dir3, 8'h00, next_st.dir0};
    next_st.n_out = next_st.nib_lat;
    next_st.n_oe  = (STD_MASK & dir_all) | (~STD_MASK & next_st.nib_lat); // RULE12 RULE16
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st          <= '0;
      st.nib_lat  <= NIB_LAT_RESET; // RULE14
      st.n_out    <= NIB_LAT_RESET;
      st.n_oe     <= ~STD_MASK & NIB_LAT_RESET;
      st.wake_n   <= 1'b1;
      st.irq0_n   <= 1'b1;
      st.irq1_n   <= 1'b1;
    end
    else
      st <= next_st;
  end

  assign nibble_rdata        = st.rdata;
  assign nibble_rvalid       = st.rvalid;
  assign discrete_pin_out    = st.d_out;
  assign discrete_pin_oe     = st.d_oe;
  assign nibble_pin_out      = st.n_out;
  assign nibble_pin_oe       = st.n_oe;
  assign stop_clear_input_n  = st.wake_n;
  assign timer_event_input   = st.evt;
  assign external_irq_zero_n = st.irq0_n;
  assign external_irq_one_n  = st.irq1_n;
  assign port_mode_a         = st.mode_a;
  assign serial_mode         = st.ser_mode;
  assign converter_mode_one  = st.conv_one;
  assign converter_mode_two  = st.conv_two;

  set_bit_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE1
    set_discrete_bit && !stop_mode && discrete_index == 4'h5
    |=> discrete_pin_out[5] && discrete_pin_oe[5])
    else $error("set did not drive pin high");
  clear_bit_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE1
    clear_discrete_bit && !set_discrete_bit && discrete_index == 4'h7
    |=> !discrete_pin_oe[7])
    else $error("clear left pin driven");
  stop_clear_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE2
    stop_mode |=> discrete_pin_oe == '0 && nibble_pin_oe == (~STD_MASK & NIB_LAT_RESET))
    else $error("stop did not release pins");
  alarm_route_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE4
    $past(st.mode_a[3]) == 1'b1 && st.mode_a[3] |-> discrete_pin_out[3] == $past(alarm_output))
    else $error("alarm not routed");
  irq_route_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE8
    reg_write && !stop_mode && reg_addr == port_io_pkg::OFS_PORT_MODE_B && reg_wdata[0]
    |=> external_irq_zero_n == $past(discrete_pin_in[0]) && !discrete_pin_oe[0])
    else $error("irq0 not routed");
  nib_write_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE10
    nibble_write && !stop_mode && nibble_port == 3'h1
    |=> nibble_pin_out[7:4] == $past(nibble_wdata))
    else $error("nibble latch not stored");
  single_read_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE11
    nibble_read && nibble_port == 3'h6
    |=> nibble_rvalid && nibble_rdata[1] == $past(single_input_bit))
    else $error("single bit read wrong");
  dir_enable_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE12
    reg_write && !stop_mode && reg_addr == port_io_pkg::OFS_DIR_PORT_THREE
    |=> nibble_pin_oe[15:12] == $past(reg_wdata))
    else $error("direction not applied");
  event_route_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE6
    !st.mode_b[2] |-> !timer_event_input)
    else $error("event input leaked");
  set_wins_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE1
    set_discrete_bit && clear_discrete_bit && !stop_mode && discrete_index == 4'h6
    |=> discrete_pin_out[6] && discrete_pin_oe[6])
    else $error("set lost to clear");
  index_range_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE1
    (set_discrete_bit || clear_discrete_bit) && !stop_mode && discrete_index > 4'h8
    |=> $stable(st.disc_lat))
    else $error("index above eight moved a latch");
  stop_hold_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE14
    stop_mode
    |=> port_mode_a == port_io_pkg::MODE_RESET && nibble_pin_out == NIB_LAT_RESET)
    else $error("stop left a latch or mode set");
  wake_route_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE5
    reg_write && !stop_mode && reg_addr == port_io_pkg::OFS_PORT_MODE_B && reg_wdata[3]
    |=> stop_clear_input_n == $past(discrete_pin_in[4]) && !discrete_pin_oe[4])
    else $error("stop clear not routed");
  irq1_route_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE7
    reg_write && !stop_mode && reg_addr == port_io_pkg::OFS_PORT_MODE_B && reg_wdata[1]
    |=> external_irq_one_n == $past(discrete_pin_in[1]) && !discrete_pin_oe[1])
    else $error("irq1 not routed");
  event_pass_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE6
    reg_write && !stop_mode && reg_addr == port_io_pkg::OFS_PORT_MODE_B && reg_wdata[2]
    |=> timer_event_input == $past(discrete_pin_in[2]) && !discrete_pin_oe[2])
    else $error("event input not routed");
  hv_drive_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE16
    nibble_write && !stop_mode && nibble_port == 3'h2
    |=> nibble_pin_oe[11:8] == $past(nibble_wdata)
        && nibble_pin_out[11:8] == $past(nibble_wdata))
    else $error("high-voltage drive wrong");
  dir_off_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE15
    reg_write && !stop_mode && reg_addr == port_io_pkg::OFS_DIR_PORT_ZERO && reg_wdata == 4'h0
    |=> nibble_pin_oe[3:0] == 4'h0)
    else $error("direction zero left pin driven");
  rvalid_pulse_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE10
    !nibble_read
    |=> !nibble_rvalid)
    else $error("read valid without read");
  nib_read_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE10
    nibble_read && nibble_port == 3'h3
    |=> nibble_rdata == $past(nibble_pin_in[15:12]))
    else $error("nibble read wrong");
  mode_copy_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE18
    reg_write && !stop_mode && reg_addr == port_io_pkg::OFS_SERIAL_MODE
    |=> serial_mode == $past(reg_wdata))
    else $error("serial mode copy wrong");
  conv_copy_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE18
    reg_write && !stop_mode && reg_addr == port_io_pkg::OFS_CONV_MODE_ONE
    |=> converter_mode_one == $past(reg_wdata))
    else $error("converter mode copy wrong");
  alarm_drive_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE17
    reg_write && !stop_mode && reg_addr == port_io_pkg::OFS_PORT_MODE_A && reg_wdata[3]
    |=> discrete_pin_oe[3] == $past(alarm_output)
        && discrete_pin_out[3] == $past(alarm_output))
    else $error("alarm did not replace latch");

  alarm_cov: cover property (@(posedge ref_clk) disable iff (!arst_n)
    st.mode_a[3] && discrete_pin_out[3]);
  read_cov: cover property (@(posedge ref_clk) disable iff (!arst_n)
    nibble_rvalid ##1 nibble_rvalid);
  stop_cov: cover property (@(posedge ref_clk) disable iff (!arst_n)
    set_discrete_bit ##1 stop_mode);
  irq_cov: cover property (@(posedge ref_clk) disable iff (!arst_n)
    st.mode_b[0] && !external_irq_zero_n);
  event_cov: cover property (@(posedge ref_clk) disable iff (!arst_n)
    st.mode_b[2] && timer_event_input);
endmodule

// ===== verilog/port_io_pkg.sv
package port_io_pkg;
  // memory-mapped offsets
  localparam logic [6:0] OFS_PORT_MODE_A     = 7'h04;
  localparam logic [6:0] OFS_SERIAL_MODE     = 7'h05;
  localparam logic [6:0] OFS_CONV_MODE_ONE   = 7'h19;
  localparam logic [6:0] OFS_CONV_MODE_TWO   = 7'h1A;
  localparam logic [6:0] OFS_PORT_MODE_B     = 7'h24;
  localparam logic [6:0] OFS_DIR_PORT_ZERO   = 7'h30;
  localparam logic [6:0] OFS_DIR_PORT_THREE  = 7'h33;
  localparam logic [6:0] OFS_DIR_PORT_FOUR   = 7'h34;
  // field positions
  localparam int ALARM_SEL_BIT      = 3;
  localparam int STOP_CLEAR_SEL_BIT = 3;
  localparam int EVENT_SEL_BIT      = 2;
  localparam int IRQ1_SEL_BIT       = 1;
  localparam int IRQ0_SEL_BIT       = 0;
  localparam int SINGLE_INPUT_BIT   = 1;
  // discrete pin numbers with shared functions
  localparam int PIN_IRQ0  = 0;
  localparam int PIN_IRQ1  = 1;
  localparam int PIN_EVENT = 2;
  localparam int PIN_ALARM = 3;
  localparam int PIN_WAKE  = 4;
  // nibble port numbers
  localparam logic [2:0] NPORT_ZERO   = 3'h0;
  localparam logic [2:0] NPORT_ONE    = 3'h1;
  localparam logic [2:0] NPORT_TWO    = 3'h2;
  localparam logic [2:0] NPORT_THREE  = 3'h3;
  localparam logic [2:0] NPORT_FOUR   = 3'h4;
  localparam logic [2:0] NPORT_EIGHT  = 3'h5;
  localparam logic [2:0] NPORT_SINGLE = 3'h6;
  // reset values
  localparam logic [3:0] MODE_RESET     = 4'h0;
  localparam logic [3:0] DIR_RESET      = 4'h0;
  localparam logic [3:0] STD_LAT_RESET  = 4'hF;
  localparam logic [3:0] HV_LAT_RESET   = 4'h0;
  localparam logic [8:0] DISC_LAT_RESET = 9'h000;
endpackage
